// file: design/dpsp_port.sv
// Purpose: slave serial port and register file of a dual digital potentiometer
// Assumes: serial pins come from another domain and are synchronised here
// Notes: writes queue in a fifo and commit only at chip select release
`default_nettype none
// Operation
// - sample input on rising clock, select low
// - shift read data on falling clock
// - control bit 1 selects open drain
// - output defaults to push pull
// - select low means active state
// - wait for first select fall
// - select high floats serial output
// - standby unless nonvolatile write running
// - wiper tap follows wiper register
// - nonvolatile write self timed after release
// - msb first, mode 0 slave
// - first byte: opcode then address
// - writes commit at select rise
// - write busy 20 ms, only control readable
module dpsp_port (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe_n,
	output logic active,
	output logic [7:0] wiper_tap0,
	output logic [7:0] wiper_tap1,
	output logic shutdown
);
	logic [1:0] sck_s_q, cs_s_q, sdi_s_q;
	logic sck_prev_q, cs_prev_q;
	dpsp_pkg::dpsp_state_t st_q, st_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, instr_q, instr_d, rd_q, rd_d;
	logic have_instr_q, have_instr_d;
	logic [7:0] wiper_q [2];
	logic [7:0] wiper_d [2];
	logic [7:0] ivr_q [16];
	logic [7:0] acr_q, acr_d;
	logic [31:0] busy_q, busy_d;
	logic sdo_q, sdo_d, oe_n_q, oe_n_d, active_q, active_d;
	logic commit_q, commit_d;
	logic sdo_pin_q, sdo_pin_d, shdn_q, shdn_d;
	logic rise, fall, cs_fall, cs_rise, cs_low, byte_done;
	logic [7:0] byte_in;
	logic f_valid, f_ready, q_valid, q_ready, nv_wr;
	dpsp_pkg::dpsp_wr_t f_in, q_out;
	function automatic logic [7:0] reg_read(input logic [4:0] a, input logic [7:0] access_control_register,
		input logic [7:0] w0, input logic [7:0] w1, input logic [7:0] nv);
		logic [7:0] r;
		r = 8'h00;
		if (a == dpsp_pkg::ADDR_ACR)
			r = access_control_register;
		else if (a <= dpsp_pkg::ADDR_WIPER1 && access_control_register[dpsp_pkg::ACR_VOL_BIT])
			r = a[0] ? w1 : w0;
		else if (a <= dpsp_pkg::ADDR_GP_LAST && !access_control_register[dpsp_pkg::ACR_VOL_BIT])
			r = nv;
		return r;
	endfunction : reg_read
	assign cs_low = !cs_s_q[1];
	assign rise = sck_s_q[1] && !sck_prev_q;
	assign fall = !sck_s_q[1] && sck_prev_q;
	assign cs_fall = cs_prev_q && !cs_s_q[1];
	assign cs_rise = !cs_prev_q && cs_s_q[1];
	assign byte_in = {sh_q[6:0], sdi_s_q[1]};
	assign byte_done = rise && cs_low && bit_q == 3'h7;
	// write queue, drained only after select rises
	dpsp_fifo #(.WIDTH(13), .DEPTH(dpsp_pkg::FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.in_data(f_in),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_out)
	);
	always_comb
	begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		instr_d = instr_q;
		have_instr_d = have_instr_q;
		rd_d = rd_q;
		sdo_d = sdo_q;
		f_valid = 1'b0;
		f_in.addr = instr_q[4:0];
		f_in.data = byte_in;
		commit_d = commit_q;
		// transfer state: nothing starts before the first select fall
		case (st_q)
			dpsp_pkg::ST_WAIT_CS:
				if (cs_fall)
					st_d = dpsp_pkg::ST_XFER;
			dpsp_pkg::ST_IDLE:
				if (cs_fall)
					st_d = dpsp_pkg::ST_XFER;
			dpsp_pkg::ST_XFER:
				if (cs_rise)
					st_d = dpsp_pkg::ST_IDLE;
			default:
				st_d = dpsp_pkg::ST_WAIT_CS;
		endcase
		if (cs_fall)
		begin
			bit_d = 3'h0;
			have_instr_d = 1'b0;
			commit_d = 1'b0;
		end
		else if (st_q == dpsp_pkg::ST_XFER && rise && cs_low)
		begin
			sh_d = byte_in;
			bit_d = bit_q + 3'h1;
			if (byte_done && !have_instr_q)
			begin
				instr_d = byte_in;
				have_instr_d = 1'b1;
				rd_d = reg_read(byte_in[4:0], acr_q, wiper_q[0], wiper_q[1],
					ivr_q[byte_in[3:0]]);
				if (busy_q != 0 && byte_in[4:0] != dpsp_pkg::ADDR_ACR)
					rd_d = 8'h00;
			end
			else if (byte_done && instr_q[7:5] == dpsp_pkg::OP_WRITE && busy_q == 0)
				f_valid = f_ready;
		end
		if (st_q == dpsp_pkg::ST_XFER && fall && cs_low)
		begin
			if (have_instr_q && instr_q[7:5] == dpsp_pkg::OP_READ)
				sdo_d = rd_q[3'h7 - bit_q];
		end
		if (st_q == dpsp_pkg::ST_XFER && cs_rise)
			commit_d = 1'b1;
		if (!q_valid)
			commit_d = 1'b0;
	end
	assign q_ready = commit_q;
	assign nv_wr = q_valid && q_ready && q_out.addr <= dpsp_pkg::ADDR_GP_LAST
		&& !acr_q[dpsp_pkg::ACR_VOL_BIT];
	always_comb
	begin
		acr_d = acr_q;
		wiper_d = wiper_q;
		busy_d = busy_q;
		// self-timed write countdown, needs no serial clock
		if (busy_q != 0)
			busy_d = busy_q - 32'h1;
		if (q_valid && q_ready)
		begin
			if (q_out.addr == dpsp_pkg::ADDR_ACR)
			begin
				acr_d = q_out.data;
				acr_d[dpsp_pkg::ACR_WIP_BIT] = 1'b0;
				acr_d[4:2] = 3'h0;
				acr_d[0] = 1'b0;
			end
			else if (q_out.addr <= dpsp_pkg::ADDR_WIPER1)
				wiper_d[q_out.addr[0]] = q_out.data;
			if (nv_wr)
				busy_d = 32'(dpsp_pkg::NV_WRITE_CYC);
		end
		acr_d[dpsp_pkg::ACR_WIP_BIT] = busy_d != 0;
		// output: floated when deselected, open drain only drives low
		oe_n_d = 1'b1;
		if (cs_low && st_q == dpsp_pkg::ST_XFER)
			oe_n_d = acr_q[dpsp_pkg::ACR_OD_BIT] ? sdo_d : 1'b0;
		active_d = cs_low || busy_d != 0;
		// pins come straight from registers
		sdo_pin_d = acr_q[dpsp_pkg::ACR_OD_BIT] ? 1'b0 : sdo_d;
		shdn_d = !acr_d[dpsp_pkg::ACR_SHDN_BIT];
	end
	always_ff @(posedge core_clk)
	begin
		// two-flop synchronisers and edge history on the serial pins
		sck_s_q <= {sck_s_q[0], sck};
		cs_s_q <= {cs_s_q[0], cs_n};
		sdi_s_q <= {sdi_s_q[0], sdi};
		sck_prev_q <= sck_s_q[1];
		cs_prev_q <= cs_s_q[1];
		if (reset)
		begin
			st_q <= dpsp_pkg::ST_WAIT_CS;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			instr_q <= 8'h00;
			have_instr_q <= 1'b0;
			rd_q <= 8'h00;
			sdo_q <= 1'b0;
			oe_n_q <= 1'b1;
			active_q <= 1'b0;
			commit_q <= 1'b0;
			sdo_pin_q <= 1'b0;
			shdn_q <= !dpsp_pkg::ACR_RESET[dpsp_pkg::ACR_SHDN_BIT];
			acr_q <= dpsp_pkg::ACR_RESET;
			wiper_q[0] <= dpsp_pkg::WIPER_RESET;
			wiper_q[1] <= dpsp_pkg::WIPER_RESET;
			busy_q <= 32'h0;
		end
		else
		begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			instr_q <= instr_d;
			have_instr_q <= have_instr_d;
			rd_q <= rd_d;
			sdo_q <= sdo_d;
			oe_n_q <= oe_n_d;
			active_q <= active_d;
			commit_q <= commit_d;
			sdo_pin_q <= sdo_pin_d;
			shdn_q <= shdn_d;
			acr_q <= acr_d;
			wiper_q <= wiper_d;
			busy_q <= busy_d;
		end
		if (nv_wr && q_out.addr != dpsp_pkg::ADDR_RSVD)
			ivr_q[q_out.addr[3:0]] <= q_out.data;
	end
	assign sdo_o = sdo_pin_q;
	assign sdo_oe_n = oe_n_q;
	assign active = active_q;
	assign wiper_tap0 = wiper_q[0];
	assign wiper_tap1 = wiper_q[1];
	assign shutdown = shdn_q;
	a_cs_high_float: assert property (@(posedge core_clk) disable iff (reset)
		cs_s_q[1] |=> sdo_oe_n)
		else $error("output driven while deselected");
	a_no_early_op: assert property (@(posedge core_clk) disable iff (reset)
		st_q == dpsp_pkg::ST_WAIT_CS |-> !f_valid)
		else $error("operation before first select fall");
	a_counter_clear: assert property (@(posedge core_clk) disable iff (reset)
		cs_fall |=> bit_q == 3'h0 && !have_instr_q)
		else $error("counters not cleared");
	a_commit_late: assert property (@(posedge core_clk) disable iff (reset)
		cs_low && !commit_q |=> $stable(wiper_q[0]) && $stable(wiper_q[1]))
		else $error("wiper changed before release");
	a_wip_flag: assert property (@(posedge core_clk) disable iff (reset)
		busy_q != 0 |-> acr_q[dpsp_pkg::ACR_WIP_BIT])
		else $error("busy without flag");
	a_active_low: assert property (@(posedge core_clk) disable iff (reset)
		cs_low |=> active)
		else $error("not active while selected");
	a_pp_default: assert property (@(posedge core_clk)
		reset |=> !acr_q[dpsp_pkg::ACR_OD_BIT])
		else $error("open drain after reset");
	a_shift_fall: assert property (@(posedge core_clk) disable iff (reset)
		!fall |=> $stable(sdo_q))
		else $error("output moved off falling edge");

	// serial framing
	sequence s_bit_in;
		st_q == dpsp_pkg::ST_XFER && rise && cs_low && !cs_fall;
	endsequence
	sequence s_instr_byte;
		st_q == dpsp_pkg::ST_XFER && byte_done && !cs_fall && !have_instr_q;
	endsequence
	sequence s_read_fall;
		st_q == dpsp_pkg::ST_XFER && fall && cs_low && !cs_fall && have_instr_q
			&& instr_q[7:5] == dpsp_pkg::OP_READ;
	endsequence
	a_bit_capture: assert property (@(posedge core_clk) disable iff (reset)
		s_bit_in |=> bit_q == $past(bit_q) + 3'h1 && sh_q == $past(byte_in))
		else $error("serial bit not captured");
	a_instr_capture: assert property (@(posedge core_clk) disable iff (reset)
		s_instr_byte |=> have_instr_q && instr_q == $past(byte_in))
		else $error("instruction byte not captured");
	a_read_shift: assert property (@(posedge core_clk) disable iff (reset)
		s_read_fall |=> sdo_q == rd_q[3'h7 - bit_q])
		else $error("read bit not launched");
	a_wait_hold: assert property (@(posedge core_clk) disable iff (reset)
		st_q == dpsp_pkg::ST_WAIT_CS && !cs_fall |=> st_q == dpsp_pkg::ST_WAIT_CS)
		else $error("left wait state without select fall");
	a_partial_drop: assert property (@(posedge core_clk) disable iff (reset)
		!have_instr_q |-> !f_valid)
		else $error("write queued without instruction");
	a_commit_release: assert property (@(posedge core_clk) disable iff (reset)
		commit_q |-> !cs_low || cs_fall)
		else $error("commit while selected");

	// output driver
	a_od_low: assert property (@(posedge core_clk) disable iff (reset)
		acr_q[dpsp_pkg::ACR_OD_BIT] |=> !sdo_o)
		else $error("open drain drove high");

	// nonvolatile write
	a_nv_countdown: assert property (@(posedge core_clk) disable iff (reset)
		busy_q != 32'h0 && !nv_wr |=> busy_q == $past(busy_q) - 32'h1)
		else $error("write timer did not count down");
	a_busy_refuse: assert property (@(posedge core_clk) disable iff (reset)
		busy_q != 32'h0 |-> !f_valid)
		else $error("write accepted while busy");
	a_standby_idle: assert property (@(posedge core_clk) disable iff (reset)
		!cs_low && busy_q == 32'h0 && !nv_wr |=> !active)
		else $error("not in standby while deselected");
endmodule : dpsp_port
`default_nettype wire

// file: design/dpsp_pkg.sv
// Purpose: shared constants and types for the dual pot serial slave port
// Assumes: core_clk at 10 MHz
// Notes: serial pins are oversampled by core_clk
`default_nettype none
package dpsp_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned NV_WRITE_MS = 20;
	localparam int unsigned NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);
	localparam logic [4:0] ADDR_WIPER0 = 5'h00;
	localparam logic [4:0] ADDR_WIPER1 = 5'h01;
	localparam logic [4:0] ADDR_GP_LAST = 5'h0e;
	localparam logic [4:0] ADDR_RSVD = 5'h0f;
	localparam logic [4:0] ADDR_ACR = 5'h10;
	localparam int unsigned ACR_VOL_BIT = 7;
	localparam int unsigned ACR_SHDN_BIT = 6;
	localparam int unsigned ACR_WIP_BIT = 5;
	localparam int unsigned ACR_OD_BIT = 1;
	localparam logic [7:0] ACR_RESET = 8'h40;
	localparam logic [7:0] WIPER_RESET = 8'h80;
	localparam logic [2:0] OP_WRITE = 3'h3;
	localparam logic [2:0] OP_READ = 3'h4;
	localparam int unsigned FIFO_DEPTH = 32;
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] data;
	} dpsp_wr_t;
	typedef enum logic [1:0] {
		ST_WAIT_CS,
		ST_IDLE,
		ST_XFER
	} dpsp_state_t;
endpackage : dpsp_pkg
`default_nettype wire

// file: design/dpsp_fifo.sv
// Purpose: write queue between serial receive and register commit
// Assumes: single clock
// Notes: width and depth are parameters
`default_nettype none
module dpsp_fifo #(
	parameter int unsigned WIDTH = 13,
	parameter int unsigned DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_q, wp_d, rp_q, rp_d;
	logic push, pop;
	always_comb
	begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		in_ready = (wp_q - rp_q) != (AW + 1)'(DEPTH);
		out_valid = wp_q != rp_q;
		out_data = mem[rp_q[AW-1:0]];
	end
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
		if (push)
			mem[wp_q[AW-1:0]] <= in_data;
	end
endmodule : dpsp_fifo
`default_nettype wire

// file: test/dpsp_host.sv
// Purpose: spi host model for the pot serial port, mode 0
// Assumes: core_clk at 10 MHz, sck period of 8 core clocks
// Notes: sdo line has a pull-up whenever the port releases it
`default_nettype none
module dpsp_host (
	input wire logic core_clk,
	output logic sck,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo_o,
	input wire logic sdo_oe_n,
	output logic drive_high
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sdo_line;
	assign sdo_line = !sdo_oe_n ? sdo_o : 1'b1;
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		drive_high = 1'b0;
	end
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
		int i;
		cs_n <= 1'b0;
		drive_high <= 1'b0;
		repeat (4) @(posedge core_clk);
		for (i = 0; i < nbits; i++)
		begin
			sdi <= tx[15-i];
			repeat (4) @(posedge core_clk);
			rx = {rx[6:0], sdo_line};
			drive_high <= drive_high | (sdo_o & ~sdo_oe_n);
			sck <= 1'b1;
			repeat (4) @(posedge core_clk);
			sck <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
		cs_n <= 1'b1;
		// deselect gap well above the minimum
		repeat (30) @(posedge core_clk);
	endtask : xfer
endmodule : dpsp_host
`default_nettype wire

// file: test/testbench.sv
// Purpose: self-checking bench for the pot serial port
// Assumes: volatile mode is set first; the one nonvolatile write runs last
// Notes: host model does the serial framing
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic sck, cs_n, sdi, sdo_o, sdo_oe_n, active, shutdown, drive_high;
	logic [7:0] wiper_tap0, wiper_tap1, rx;
	int failures = 0;
	int tests_run = 0;
	always #50 core_clk = ~core_clk;
	dpsp_port u_dpsp_port (.core_clk, .reset, .sck, .cs_n, .sdi, .sdo_o, .sdo_oe_n,
		.active, .wiper_tap0, .wiper_tap1, .shutdown);
	dpsp_host u_dpsp_host (.core_clk, .sck, .cs_n, .sdi, .sdo_o, .sdo_oe_n, .drive_high);
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		u_dpsp_host.xfer({dpsp_pkg::OP_WRITE, a, d}, 16, rx);
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		u_dpsp_host.xfer({dpsp_pkg::OP_READ, a, 8'h00}, 16, d);
	endtask : rd
	// bounded wait for both taps to reach a value
	task automatic settle(input logic [15:0] exp);
		int n;
		for (n = 0; n < 50 && {wiper_tap1, wiper_tap0} !== exp; n++)
			@(posedge core_clk);
		if (n == 50)
		begin
			failures++;
			complete_run();
		end
	endtask : settle
	task automatic test_reset();
		check("tap0", wiper_tap0, 8'h80);
		check("tap1", wiper_tap1, 8'h80);
		check("sdo_oe_n", sdo_oe_n, 8'h01);
		check("active", active, 8'h00);
		check("shutdown", shutdown, 8'h00);
		$display("test reset done");
	endtask : test_reset
	task automatic test_write();
		wr(dpsp_pkg::ADDR_ACR, 8'hc0);
		fork
			wr(dpsp_pkg::ADDR_WIPER0, 8'hff);
			begin
				repeat (135) @(posedge core_clk);
				check("tap0 before release", wiper_tap0, 8'h80);
			end
		join
		settle(16'h80ff);
		check("tap0", wiper_tap0, 8'hff);
		wr(dpsp_pkg::ADDR_WIPER1, 8'h00);
		settle(16'h00ff);
		check("tap1", wiper_tap1, 8'h00);
		$display("test write done");
	endtask : test_write
	task automatic test_partial();
		u_dpsp_host.xfer({dpsp_pkg::OP_WRITE, dpsp_pkg::ADDR_WIPER0, 8'h12}, 12, rx);
		check("tap0 partial", wiper_tap0, 8'hff);
		$display("test partial done");
	endtask : test_partial
	task automatic test_read();
		fork
			rd(dpsp_pkg::ADDR_WIPER0, rx);
			begin
				repeat (60) @(posedge core_clk);
				check("active selected", active, 8'h01);
			end
		join
		check("read wiper0", rx, 8'hff);
		check("push pull drive", drive_high, 8'h01);
		check("sdo_oe_n idle", sdo_oe_n, 8'h01);
		check("active idle", active, 8'h00);
		$display("test read done");
	endtask : test_read
	task automatic test_open_drain();
		wr(dpsp_pkg::ADDR_ACR, 8'hc2);
		rd(dpsp_pkg::ADDR_WIPER1, rx);
		check("read wiper1", rx, 8'h00);
		rd(dpsp_pkg::ADDR_ACR, rx);
		check("read control", rx, 8'hc2);
		check("open drain drive", drive_high, 8'h00);
		wr(dpsp_pkg::ADDR_ACR, 8'hc0);
		rd(dpsp_pkg::ADDR_WIPER0, rx);
		check("push pull again", drive_high, 8'h01);
		$display("test open drain done");
	endtask : test_open_drain
	task automatic test_shutdown();
		wr(dpsp_pkg::ADDR_ACR, 8'h80);
		check("shutdown on", shutdown, 8'h01);
		wr(dpsp_pkg::ADDR_ACR, 8'hc0);
		check("shutdown off", shutdown, 8'h00);
		check("tap0 kept", wiper_tap0, 8'hff);
		$display("test shutdown done");
	endtask : test_shutdown
	task automatic test_nv_write();
		wr(dpsp_pkg::ADDR_ACR, 8'h40);
		wr(dpsp_pkg::ADDR_GP_LAST, 8'h5a);
		check("active while writing", active, 8'h01);
		rd(dpsp_pkg::ADDR_ACR, rx);
		check("busy flag", rx, 8'h60);
		rd(dpsp_pkg::ADDR_WIPER0, rx);
		check("read refused", rx, 8'h00);
		wr(dpsp_pkg::ADDR_WIPER0, 8'h11);
		check("write refused", wiper_tap0, 8'hff);
		check("still writing", active, 8'h01);
		$display("test nv write done");
	endtask : test_nv_write
	initial
	begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		test_reset();
		test_write();
		test_partial();
		test_read();
		test_open_drain();
		test_shutdown();
		test_nv_write();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
